//--- core/iorsd_consts.svh
// offsets, masks, reset values and timing of the low i/o window
// assumes inclusion by bare name
`ifndef IORSD_CONSTS_SVH
`define IORSD_CONSTS_SVH

// i/o window layout and its mirror in data space
`define IORSD_IO_AW          6
`define IORSD_DATA_OFFSET    8'h20
`define IORSD_EXT_BASE       8'h60
`define IORSD_BIT_IO_LAST    6'h1F

// register indices inside the bit-accessible i/o range
`define IORSD_IDX_PB_PIN     5'h03
`define IORSD_IDX_PB_DIR     5'h04
`define IORSD_IDX_PB_OUT     5'h05
`define IORSD_IDX_PC_PIN     5'h06
`define IORSD_IDX_PC_DIR     5'h07
`define IORSD_IDX_PC_OUT     5'h08
`define IORSD_IDX_PD_PIN     5'h09
`define IORSD_IDX_PD_DIR     5'h0A
`define IORSD_IDX_PD_OUT     5'h0B
`define IORSD_IDX_T0_FLG     5'h15
`define IORSD_IDX_T1_FLG     5'h16
`define IORSD_IDX_T2_FLG     5'h17
`define IORSD_IDX_PC_FLG     5'h1B
`define IORSD_IDX_EX_FLG     5'h1C
`define IORSD_IDX_EX_MSK     5'h1D
`define IORSD_IDX_SCRATCH    5'h1E
`define IORSD_IDX_NV_CTL     5'h1F

// implemented bit positions; the rest reads as zero
`define IORSD_MASK_FULL      8'hFF
`define IORSD_MASK_PORT_C    8'h7F
`define IORSD_MASK_T0_FLG    8'h07
`define IORSD_MASK_T1_FLG    8'h27
`define IORSD_MASK_T2_FLG    8'h07
`define IORSD_MASK_PC_FLG    8'h07
`define IORSD_MASK_EX_FLG    8'h03
`define IORSD_MASK_EX_MSK    8'h03
`define IORSD_MASK_NV_CTL    8'h3F

// reset values
`define IORSD_RST_BYTE       8'h00

// cycles from a taken request to its answer
`define IORSD_LAT_LOCAL      1
`define IORSD_LAT_EXT_READ   2

`endif

//--- core/iorsd_flag_bank.sv
// bank of sticky status flags cleared by writing one
// assumes same-clock event and clear strobes
`timescale 1ns/10ps
`include "iorsd_consts.svh"
module iorsd_flag_bank #(
	parameter logic [7:0] MASK = 8'hFF
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// hardware events and software clear strobes
	input  wire logic [7:0] event_set,
	input  wire logic [7:0] clear_one,
	// flag state
	output logic      [7:0] flags
);

	genvar g;

	// per bit: unimplemented positions stay zero, a set beats a clear in the same cycle
	generate
		for (g = 0; g < 8; g++) begin : g_flag
			if (MASK[g]) begin : g_real
				logic flag_reg;
				always_ff @(posedge clk) begin
					if (!reset_n) begin
						flag_reg <= 1'b0;
					end else if (event_set[g]) begin
						flag_reg <= 1'b1;
					end else if (clear_one[g]) begin
						flag_reg <= 1'b0; // see RULE5
					end
				end
				assign flags[g] = flag_reg;
			end else begin : g_none
				assign flags[g] = 1'b0;
			end
		end
	endgenerate

endmodule

//--- core/iorsd_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; stage one feeds only stage two
`timescale 1ns/10ps
module iorsd_pin_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// raw pins and filtered value
	input  wire logic [WIDTH-1:0] pin_raw,
	output logic      [WIDTH-1:0] pin_value
);

	genvar g;

	// one chain per bit; the value moves only when stages two and three agree
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic val_reg;

			always_ff @(posedge clk) begin
				if (!reset_n) begin
					s1_reg  <= 1'b0;
					s2_reg  <= 1'b0;
					s3_reg  <= 1'b0;
					val_reg <= 1'b0;
				end else begin
					s1_reg <= pin_raw[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						val_reg <= s3_reg; // a one-cycle glitch is never taken
					end
				end
			end

			assign pin_value[g] = val_reg;
		end
	endgenerate

endmodule

//--- core/iorsd_pkg.sv
// types shared by the i/o register space decoder
// assumes the constant header is compiled alongside
package iorsd_pkg;

	// operation issued by the processor core in one cycle
	typedef enum logic [3:0] {
		IORSD_OP_NONE,
		IORSD_OP_IO_READ,
		IORSD_OP_IO_WRITE,
		IORSD_OP_SET_BIT,
		IORSD_OP_CLEAR_BIT,
		IORSD_OP_SKIP_HIGH,
		IORSD_OP_SKIP_LOW,
		IORSD_OP_MEM_LOAD,
		IORSD_OP_MEM_STORE
	} iorsd_op_t;

	typedef logic [7:0] iorsd_byte_t;

endpackage

//--- core/iorsd_top.sv
// decoder for the low i/o window, its data-space mirror and its bit operations
// assumes one core operation per cycle while busy is low,
// and a peripheral read answer in the cycle ext_req is high
`timescale 1ns/10ps
`include "iorsd_consts.svh"

// Behaviour
// RULE1: software writes zero into reserved bit positions it touches.
// RULE2: software never writes a reserved i/o location.
// RULE3: set-bit and clear-bit modify single bits of registers at i/o 0x00-0x1F.
// RULE4: skip-if-high and skip-if-low test one selected bit of those registers.
// RULE5: status flags clear on a written one; a written zero leaves them alone.
// RULE6: bit operations alter only the addressed bit.
// RULE7: bit operations act only on i/o 0x00-0x1F.
// RULE8: i/o read and write instructions use i/o addresses 0x00-0x3F.
// RULE9: data-space access reaches i/o address N at N plus 0x20.
// RULE10: the i/o address field selects one of 64 locations only.
// RULE11: extended region 0x60-0xFF is reached only through loads and stores.
// RULE12: reserved locations and bits read as zero without side effects.
module iorsd_top
	import iorsd_pkg::*;
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            reset_n,
	// request from the processor core
	input  wire logic            op_valid,
	input  iorsd_pkg::iorsd_op_t op_kind,
	input  wire logic [5:0]      op_io_addr,
	input  wire logic [7:0]      op_data_addr,
	input  wire logic [2:0]      op_bit,
	input  wire logic [7:0]      op_wdata,
	output logic                 busy,
	// answer to the processor core
	output logic                 rsp_valid,
	output logic [7:0]           rsp_rdata,
	output logic                 rsp_skip,
	output logic                 rsp_error,
	// extended region towards other peripherals
	output logic                 ext_req,
	output logic                 ext_we,
	output logic [7:0]           ext_addr,
	output logic [7:0]           ext_wdata,
	input  wire logic [7:0]      ext_rdata,
	// port pins
	input  wire logic [7:0]      port_b_pins,
	input  wire logic [6:0]      port_c_pins,
	input  wire logic [7:0]      port_d_pins,
	output logic [7:0]           port_b_out,
	output logic [7:0]           port_b_oe,
	output logic [6:0]           port_c_out,
	output logic [6:0]           port_c_oe,
	output logic [7:0]           port_d_out,
	output logic [7:0]           port_d_oe,
	// peripheral events setting status flags
	input  wire logic [7:0]      timer0_events,
	input  wire logic [7:0]      timer1_events,
	input  wire logic [7:0]      timer2_events,
	input  wire logic [7:0]      pin_change_events,
	input  wire logic [7:0]      ext_irq_events,
	// register state seen by peripherals
	output logic [7:0]           timer0_flags,
	output logic [7:0]           timer1_flags,
	output logic [7:0]           timer2_flags,
	output logic [7:0]           pin_change_flags,
	output logic [7:0]           ext_irq_flags,
	output logic [7:0]           ext_irq_mask,
	output logic [7:0]           scratch_0,
	output logic [7:0]           nv_control
);

	// stored control registers
	logic [7:0] pb_dir_reg, pb_out_reg, pd_dir_reg, pd_out_reg;
	logic [7:0] pc_dir_reg, pc_out_reg, ex_msk_reg, scratch_reg, nv_ctl_reg;
	// answer and extended bus registers
	logic       busy_reg, rsp_valid_reg, rsp_skip_reg, rsp_error_reg;
	logic [7:0] rsp_rdata_reg;
	logic       ext_req_reg, ext_we_reg;
	logic [7:0] ext_addr_reg, ext_wdata_reg;
	// synchronised pins
	logic [7:0] pb_pin_val, pd_pin_val;
	logic [6:0] pc_pin_val;
	// decode results
	logic       take, is_io_op, is_bit_op, is_mem_op, is_write, is_read;
	logic [7:0] dadr, bit_mask, local_rd, wr_value, w1c_value;
	logic [4:0] idx;
	logic       in_local, in_ext, in_cpu_regs, bit_range_ok, reserved_hit, local_we;
	logic       ext_go, skip_next, err_next;

	// clear strobes for each flag bank
	logic [7:0] clr_t0, clr_t1, clr_t2, clr_pc, clr_ex;

	assign take = op_valid && !busy_reg;

	// classify the operation
	always_comb begin
		is_bit_op = (op_kind == IORSD_OP_SET_BIT) || (op_kind == IORSD_OP_CLEAR_BIT)
			|| (op_kind == IORSD_OP_SKIP_HIGH) || (op_kind == IORSD_OP_SKIP_LOW);
		is_io_op  = is_bit_op || (op_kind == IORSD_OP_IO_READ)
			|| (op_kind == IORSD_OP_IO_WRITE);
		is_mem_op = (op_kind == IORSD_OP_MEM_LOAD) || (op_kind == IORSD_OP_MEM_STORE);
		is_write  = (op_kind == IORSD_OP_IO_WRITE) || (op_kind == IORSD_OP_MEM_STORE)
			|| (op_kind == IORSD_OP_SET_BIT) || (op_kind == IORSD_OP_CLEAR_BIT);
		is_read   = (op_kind == IORSD_OP_IO_READ) || (op_kind == IORSD_OP_MEM_LOAD);
	end

	// i/o addresses map by the fixed offset; the 6-bit field stops at 0x3F, mapped 0x5F,
	// so only loads and stores reach the extended region
	assign dadr = is_io_op ? (8'(op_io_addr) + `IORSD_DATA_OFFSET) // see RULE9 see RULE10
		: op_data_addr;
	assign idx          = dadr[4:0];
	assign in_cpu_regs  = dadr < `IORSD_DATA_OFFSET;
	assign in_local     = (dadr >= `IORSD_DATA_OFFSET) && (dadr < 8'h40); // see RULE8
	assign in_ext       = !in_local && !in_cpu_regs; // see RULE11
	assign bit_range_ok = op_io_addr <= `IORSD_BIT_IO_LAST; // see RULE3 see RULE7
	assign bit_mask     = 8'h01 << op_bit;

	// read mux of the bit-accessible range; reserved places and bits give zero
	always_comb begin
		local_rd     = 8'h00;
		reserved_hit = 1'b0;
		case (idx)
			`IORSD_IDX_PB_PIN:  local_rd = pb_pin_val;
			`IORSD_IDX_PB_DIR:  local_rd = pb_dir_reg;
			`IORSD_IDX_PB_OUT:  local_rd = pb_out_reg;
			`IORSD_IDX_PC_PIN:  local_rd = {1'b0, pc_pin_val}; // see RULE12
			`IORSD_IDX_PC_DIR:  local_rd = pc_dir_reg & `IORSD_MASK_PORT_C;
			`IORSD_IDX_PC_OUT:  local_rd = pc_out_reg & `IORSD_MASK_PORT_C;
			`IORSD_IDX_PD_PIN:  local_rd = pd_pin_val;
			`IORSD_IDX_PD_DIR:  local_rd = pd_dir_reg;
			`IORSD_IDX_PD_OUT:  local_rd = pd_out_reg;
			`IORSD_IDX_T0_FLG:  local_rd = timer0_flags;
			`IORSD_IDX_T1_FLG:  local_rd = timer1_flags;
			`IORSD_IDX_T2_FLG:  local_rd = timer2_flags;
			`IORSD_IDX_PC_FLG:  local_rd = pin_change_flags;
			`IORSD_IDX_EX_FLG:  local_rd = ext_irq_flags;
			`IORSD_IDX_EX_MSK:  local_rd = ex_msk_reg;
			`IORSD_IDX_SCRATCH: local_rd = scratch_reg;
			`IORSD_IDX_NV_CTL:  local_rd = nv_ctl_reg;
			default: begin
				local_rd     = 8'h00; // see RULE12
				reserved_hit = 1'b1;
			end
		endcase
	end

	// bit operations merge only their own bit into the contents,
	// and set-bit offers write-one-to-clear flags a one at that bit alone; clear-bit offers them zero
	always_comb begin
		wr_value  = op_wdata;
		w1c_value = op_wdata; // see RULE5
		if (op_kind == IORSD_OP_SET_BIT) begin
			wr_value  = local_rd | bit_mask; // see RULE3 see RULE6
			w1c_value = bit_mask; // see RULE6
		end else if (op_kind == IORSD_OP_CLEAR_BIT) begin
			wr_value  = local_rd & ~bit_mask; // see RULE6
			w1c_value = 8'h00; // see RULE6
		end
	end

	// a write lands only in a mapped, in-range location; reserved writes are dropped
	assign local_we = take && is_write && in_local && !reserved_hit // see RULE2
		&& (!is_bit_op || bit_range_ok); // see RULE7

	// clear strobes, one per flag bank
	always_comb begin
		clr_t0 = 8'h00;
		clr_t1 = 8'h00;
		clr_t2 = 8'h00;
		clr_pc = 8'h00;
		clr_ex = 8'h00;
		if (local_we) begin
			case (idx)
				`IORSD_IDX_T0_FLG: clr_t0 = w1c_value; // see RULE5
				`IORSD_IDX_T1_FLG: clr_t1 = w1c_value;
				`IORSD_IDX_T2_FLG: clr_t2 = w1c_value;
				`IORSD_IDX_PC_FLG: clr_pc = w1c_value;
				`IORSD_IDX_EX_FLG: clr_ex = w1c_value;
				default:           clr_t0 = 8'h00;
			endcase
		end
	end

	// port b control
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pb_dir_reg <= `IORSD_RST_BYTE;
			pb_out_reg <= `IORSD_RST_BYTE;
		end else if (local_we && idx == `IORSD_IDX_PB_DIR) begin
			pb_dir_reg <= wr_value;
		end else if (local_we && idx == `IORSD_IDX_PB_OUT) begin
			pb_out_reg <= wr_value;
		end
	end

	// port c control; bit 7 is absent and never stored
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pc_dir_reg <= `IORSD_RST_BYTE;
			pc_out_reg <= `IORSD_RST_BYTE;
		end else if (local_we && idx == `IORSD_IDX_PC_DIR) begin
			pc_dir_reg <= wr_value & `IORSD_MASK_PORT_C;
		end else if (local_we && idx == `IORSD_IDX_PC_OUT) begin
			pc_out_reg <= wr_value & `IORSD_MASK_PORT_C;
		end
	end

	// port d control
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pd_dir_reg <= `IORSD_RST_BYTE;
			pd_out_reg <= `IORSD_RST_BYTE;
		end else if (local_we && idx == `IORSD_IDX_PD_DIR) begin
			pd_dir_reg <= wr_value;
		end else if (local_we && idx == `IORSD_IDX_PD_OUT) begin
			pd_out_reg <= wr_value;
		end
	end

	// mask, scratch and non-volatile control bytes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ex_msk_reg  <= `IORSD_RST_BYTE;
			scratch_reg <= `IORSD_RST_BYTE;
			nv_ctl_reg  <= `IORSD_RST_BYTE;
		end else if (local_we) begin
			if (idx == `IORSD_IDX_EX_MSK) begin
				ex_msk_reg <= wr_value & `IORSD_MASK_EX_MSK; // see RULE12
			end
			if (idx == `IORSD_IDX_SCRATCH) begin
				scratch_reg <= wr_value;
			end
			if (idx == `IORSD_IDX_NV_CTL) begin
				nv_ctl_reg <= wr_value & `IORSD_MASK_NV_CTL;
			end
		end
	end

	// skip decision and error for the answer
	always_comb begin
		skip_next = 1'b0;
		if (in_local && bit_range_ok) begin
			if (op_kind == IORSD_OP_SKIP_HIGH) begin
				skip_next = local_rd[op_bit]; // see RULE4
			end else if (op_kind == IORSD_OP_SKIP_LOW) begin
				skip_next = !local_rd[op_bit]; // see RULE4
			end
		end
		err_next = (op_kind == IORSD_OP_NONE) || in_cpu_regs
			|| (is_bit_op && !bit_range_ok) // see RULE7
			|| (is_write && in_local && reserved_hit); // see RULE2
	end

	// extended reads answer a cycle later, so the core is held off meanwhile
	assign ext_go = take && in_ext && (is_read || is_write) && !is_bit_op;

	// answer towards the core
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			busy_reg      <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_rdata_reg <= 8'h00;
			rsp_skip_reg  <= 1'b0;
			rsp_error_reg <= 1'b0;
		end else if (busy_reg) begin
			busy_reg      <= 1'b0;
			rsp_valid_reg <= 1'b1;
			rsp_rdata_reg <= ext_rdata;
			rsp_skip_reg  <= 1'b0;
			rsp_error_reg <= 1'b0;
		end else begin
			busy_reg      <= ext_go && is_read;
			rsp_valid_reg <= take && !(ext_go && is_read);
			rsp_rdata_reg <= (take && is_read && in_local) ? local_rd : 8'h00;
			rsp_skip_reg  <= take && skip_next;
			rsp_error_reg <= take && err_next;
		end
	end

	// request towards peripherals of the extended region and upper i/o window
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ext_req_reg   <= 1'b0;
			ext_we_reg    <= 1'b0;
			ext_addr_reg  <= 8'h00;
			ext_wdata_reg <= 8'h00;
		end else begin
			ext_req_reg <= ext_go; // see RULE11
			ext_we_reg  <= ext_go && is_write;
			if (ext_go) begin
				ext_addr_reg  <= dadr;
				ext_wdata_reg <= op_wdata;
			end
		end
	end

	// pin synchronisers; pin reads have no side effect
	iorsd_pin_sync #(.WIDTH(8)) u_sync_b (
		.clk       (clk),
		.reset_n   (reset_n),
		.pin_raw   (port_b_pins),
		.pin_value (pb_pin_val)
	);
	iorsd_pin_sync #(.WIDTH(7)) u_sync_c (
		.clk       (clk),
		.reset_n   (reset_n),
		.pin_raw   (port_c_pins),
		.pin_value (pc_pin_val)
	);
	iorsd_pin_sync #(.WIDTH(8)) u_sync_d (
		.clk       (clk),
		.reset_n   (reset_n),
		.pin_raw   (port_d_pins),
		.pin_value (pd_pin_val)
	);

	// flag banks
	iorsd_flag_bank #(.MASK(`IORSD_MASK_T0_FLG)) u_flg_t0 (
		.clk       (clk),
		.reset_n   (reset_n),
		.event_set (timer0_events),
		.clear_one (clr_t0),
		.flags     (timer0_flags)
	);
	iorsd_flag_bank #(.MASK(`IORSD_MASK_T1_FLG)) u_flg_t1 (
		.clk       (clk),
		.reset_n   (reset_n),
		.event_set (timer1_events),
		.clear_one (clr_t1),
		.flags     (timer1_flags)
	);
	iorsd_flag_bank #(.MASK(`IORSD_MASK_T2_FLG)) u_flg_t2 (
		.clk       (clk),
		.reset_n   (reset_n),
		.event_set (timer2_events),
		.clear_one (clr_t2),
		.flags     (timer2_flags)
	);
	iorsd_flag_bank #(.MASK(`IORSD_MASK_PC_FLG)) u_flg_pc (
		.clk       (clk),
		.reset_n   (reset_n),
		.event_set (pin_change_events),
		.clear_one (clr_pc),
		.flags     (pin_change_flags)
	);
	iorsd_flag_bank #(.MASK(`IORSD_MASK_EX_FLG)) u_flg_ex (
		.clk       (clk),
		.reset_n   (reset_n),
		.event_set (ext_irq_events),
		.clear_one (clr_ex),
		.flags     (ext_irq_flags)
	);

	// outputs straight from flip-flops
	assign busy         = busy_reg;
	assign rsp_valid    = rsp_valid_reg;
	assign rsp_rdata    = rsp_rdata_reg;
	assign rsp_skip     = rsp_skip_reg;
	assign rsp_error    = rsp_error_reg;
	assign ext_req      = ext_req_reg;
	assign ext_we       = ext_we_reg;
	assign ext_addr     = ext_addr_reg;
	assign ext_wdata    = ext_wdata_reg;
	assign port_b_out   = pb_out_reg;
	assign port_b_oe    = pb_dir_reg;
	assign port_c_out   = pc_out_reg[6:0];
	assign port_c_oe    = pc_dir_reg[6:0];
	assign port_d_out   = pd_out_reg;
	assign port_d_oe    = pd_dir_reg;
	assign ext_irq_mask = ex_msk_reg;
	assign scratch_0    = scratch_reg;
	assign nv_control   = nv_ctl_reg;

endmodule

//--- testbench/iorsd_core_model.sv
// behavioural core: one operation at a time, waits for its answer
// assumes requests change only on falling edges
`timescale 1ns/10ps
module iorsd_core_model
	import iorsd_pkg::*;
(
	// clock
	input wire logic        clk,
	// request
	output logic            op_valid,
	output iorsd_op_t       op_kind,
	output logic [5:0]      op_io_addr,
	output logic [7:0]      op_data_addr,
	output logic [2:0]      op_bit,
	output logic [7:0]      op_wdata,
	// answer
	input wire logic        busy,
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_rdata,
	input wire logic        rsp_skip,
	input wire logic        rsp_error
);
	initial begin
		op_valid = 1'b0;
		op_kind = IORSD_OP_NONE;
		{op_io_addr, op_data_addr, op_bit, op_wdata} = '0;
	end
	// reserved bits go as zero; reserved places are written only to test refusal
	task automatic issue(input iorsd_op_t k, input logic [5:0] a, input logic [7:0] d,
		input logic [2:0] b, input logic [7:0] w, output logic [7:0] rd, output logic sk,
		output logic er);
		rd = 8'hXX;
		sk = 1'bx;
		er = 1'bx;
		@(negedge clk);
		{op_valid, op_kind, op_io_addr, op_data_addr, op_bit, op_wdata} = {1'b1, k, a, d, b, w};
		@(posedge clk);
		// bounded wait for the answer
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			if (i == 0) begin
				op_valid = 1'b0;
				{op_io_addr, op_data_addr, op_wdata} = ~{op_io_addr, op_data_addr, op_wdata};
			end
			if (rsp_valid === 1'b1) begin
				{rd, sk, er} = {rsp_rdata, rsp_skip, rsp_error};
				break;
			end
		end
	endtask
endmodule

//--- testbench/iorsd_top_monitor.sv
// concurrent checks on the decoder's ports
// assumes one clock and a bind from the bench top
`timescale 1ns/10ps
module iorsd_top_monitor
	import iorsd_pkg::*;
(
	// clock and reset
	input wire logic           clk,
	input wire logic           reset_n,
	// core request and answer
	input wire logic           op_valid,
	input iorsd_pkg::iorsd_op_t op_kind,
	input wire logic [5:0]     op_io_addr,
	input wire logic [7:0]     op_data_addr,
	input wire logic [2:0]     op_bit,
	input wire logic [7:0]     op_wdata,
	input wire logic           busy,
	input wire logic           rsp_valid,
	input wire logic [7:0]     rsp_rdata,
	input wire logic           rsp_skip,
	input wire logic           rsp_error,
	// extended port and watched registers
	input wire logic           ext_req,
	input wire logic           ext_we,
	input wire logic [7:0]     ext_addr,
	input wire logic [7:0]     port_b_out,
	input wire logic [7:0]     port_b_oe,
	input wire logic [7:0]     timer1_events,
	input wire logic [7:0]     timer1_flags,
	input wire logic [7:0]     ext_irq_events,
	input wire logic [7:0]     ext_irq_flags
);
	// rising edge, quiet in reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic take;
	// taken request
	assign take = op_valid && !busy;

	AST_LOCAL_ANSWER: assert property (take && op_kind == IORSD_OP_IO_WRITE && !op_io_addr[5] |=> rsp_valid)
		else $error("no local answer");
	AST_EXT_MIRROR: assert property (take && op_kind == IORSD_OP_IO_READ && op_io_addr[5] |=> ext_req && !ext_we && busy && ext_addr == ({2'b00, $past(op_io_addr)} + 8'h20) ##1 rsp_valid && !busy)
		else $error("bad mirror");
	AST_BIT_RANGE: assert property (take && op_kind inside {IORSD_OP_SET_BIT, IORSD_OP_CLEAR_BIT, IORSD_OP_SKIP_HIGH, IORSD_OP_SKIP_LOW} && op_io_addr[5] |=> rsp_valid && rsp_error && !ext_req)
		else $error("bit op range");
	AST_SET_ONE: assert property (take && op_kind == IORSD_OP_SET_BIT && op_io_addr == 6'h05 |=> port_b_out == ($past(port_b_out) | (8'h01 << $past(op_bit))))
		else $error("set bit wrong");
	AST_CLR_ONE: assert property (take && op_kind == IORSD_OP_CLEAR_BIT && op_io_addr == 6'h04 |=> port_b_oe == ($past(port_b_oe) & ~(8'h01 << $past(op_bit))))
		else $error("clear bit wrong");
	AST_SKIP: assert property (take && op_kind == IORSD_OP_SKIP_HIGH && op_io_addr == 6'h05 |=> rsp_valid && rsp_skip == |($past(port_b_out) & (8'h01 << $past(op_bit))))
		else $error("skip wrong");
	AST_W1C: assert property (take && op_kind == IORSD_OP_IO_WRITE && op_io_addr == 6'h1C && ext_irq_events == 8'h00 |=> ext_irq_flags == ($past(ext_irq_flags) & ~$past(op_wdata)))
		else $error("w1c wrong");
	AST_CLR_KEEPS_FLAGS: assert property (take && op_kind == IORSD_OP_CLEAR_BIT && op_io_addr == 6'h16 && timer1_events == 8'h00 |=> $stable(timer1_flags))
		else $error("flags altered");
	AST_EXT_ONLY_MEM: assert property (ext_req && ext_addr >= 8'h60 |-> $past(op_kind) inside {IORSD_OP_MEM_LOAD, IORSD_OP_MEM_STORE})
		else $error("io op went extended");
	AST_RSVD_ZERO: assert property (take && op_kind == IORSD_OP_IO_READ && op_io_addr inside {[6'h0C:6'h14]} |=> rsp_valid && rsp_rdata == 8'h00)
		else $error("reserved not zero");
	AST_LOW_DATA: assert property (take && op_kind == IORSD_OP_MEM_LOAD && op_data_addr < 8'h20 |=> rsp_valid && rsp_error && !ext_req)
		else $error("low data not refused");
endmodule

//--- testbench/tb_io_register_space_decode.sv
// self-checking bench: core model issues operations, bench plays pins and peripheral
// assumes an answer within three cycles of a take
`timescale 1ns/10ps
`include "iorsd_consts.svh"
module tb_io_register_space_decode;
	import iorsd_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0;
	logic op_valid, busy, rsp_valid, rsp_skip, rsp_error, ext_req, ext_we, sk, er;
	iorsd_op_t op_kind;
	logic [5:0] op_io_addr;
	logic [2:0] op_bit;
	logic [7:0] op_data_addr, op_wdata, rsp_rdata, ext_addr, ext_wdata, ext_rdata, rd, ev = '0;
	logic [7:0] pb = '0, pd = '0, pv;
	logic [6:0] pc = '0;
	logic [7:0] b_out, b_oe, d_out, d_oe, t0f, t1f, t2f, pcf, exf, exm, scr, nvc;
	logic [6:0] c_out, c_oe;
	int mismatches = 0, num_checks = 0;
	localparam logic [5:0] RA [9] = '{6'h04, 6'h05, 6'h07, 6'h08, 6'h0A, 6'h0B, 6'h1D, 6'h1E, 6'h1F};
	localparam logic [7:0] RM [9] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'h3F};
	localparam logic [5:0] FA [5] = '{6'h15, 6'h16, 6'h17, 6'h1B, 6'h1C};
	localparam logic [7:0] FM [5] = '{8'h07, 8'h27, 8'h07, 8'h07, 8'h03};
	localparam logic [5:0] RS [3] = '{6'h00, 6'h0C, 6'h18};

	// 200 MHz clock
	always #2.5 clk = ~clk;
	// peripheral answers from its address; a changing pattern when not selected
	assign ext_rdata = ext_req ? (ext_addr ^ 8'h5A) : ~ext_addr;

	iorsd_core_model i_core (.clk, .op_valid, .op_kind, .op_io_addr, .op_data_addr, .op_bit,
		.op_wdata, .busy, .rsp_valid, .rsp_rdata, .rsp_skip, .rsp_error);
	iorsd_top i_dut (.clk, .reset_n, .op_valid, .op_kind, .op_io_addr, .op_data_addr, .op_bit,
		.op_wdata, .busy, .rsp_valid, .rsp_rdata, .rsp_skip, .rsp_error, .ext_req, .ext_we,
		.ext_addr, .ext_wdata, .ext_rdata, .port_b_pins(pb), .port_c_pins(pc), .port_d_pins(pd),
		.port_b_out(b_out), .port_b_oe(b_oe), .port_c_out(c_out), .port_c_oe(c_oe),
		.port_d_out(d_out), .port_d_oe(d_oe), .timer0_events(ev), .timer1_events(ev),
		.timer2_events(ev), .pin_change_events(ev), .ext_irq_events(ev), .timer0_flags(t0f),
		.timer1_flags(t1f), .timer2_flags(t2f), .pin_change_flags(pcf), .ext_irq_flags(exf),
		.ext_irq_mask(exm), .scratch_0(scr), .nv_control(nvc));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic op(input iorsd_op_t k, input logic [5:0] a, input logic [7:0] d,
		input logic [2:0] b, input logic [7:0] w);
		i_core.issue(k, a, d, b, w, rd, sk, er);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watchdog: the sequence needs well under 1500 cycles
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		test_done();
	end

	initial begin
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		check(b_out, 8'h00);
		check(t1f, 8'h00);
		// every read-write register: implemented bits stick, others read zero
		for (int i = 0; i < 9; i++) begin
			op(IORSD_OP_IO_WRITE, RA[i], 8'h00, 3'd0, RM[i]);
			check({7'h00, er}, 8'h00);
			op(IORSD_OP_IO_READ, RA[i], 8'h00, 3'd0, 8'h00);
			check(rd, RM[i]);
		end
		check({1'b0, c_oe}, 8'h7F);
		check(nvc, 8'h3F);
		check(exm, 8'h03);
		check(scr, 8'hFF);
		check({1'b0, c_out}, 8'h7F);
		check(d_out, 8'hFF);
		check(d_oe, 8'hFF);
		// data-space mirror at plus 20
		op(IORSD_OP_MEM_STORE, 6'h00, 8'h25, 3'd0, 8'h3C);
		check(b_out, 8'h3C);
		op(IORSD_OP_MEM_LOAD, 6'h00, 8'h3E, 3'd0, 8'h00);
		check(rd, 8'hFF);
		// single-bit set and clear, a set out of range, then skip-if-high and skip-if-low on every bit
		op(IORSD_OP_CLEAR_BIT, 6'h05, 8'h00, 3'd2, 8'h00);
		check(b_out, 8'h38);
		op(IORSD_OP_SET_BIT, 6'h05, 8'h00, 3'd7, 8'h00);
		check(b_out, 8'hB8);
		op(IORSD_OP_CLEAR_BIT, 6'h04, 8'h00, 3'd0, 8'h00);
		check(b_oe, 8'hFE);
		op(IORSD_OP_SET_BIT, 6'h25, 8'h00, 3'd0, 8'h00);
		check({7'h00, er}, 8'h01);
		check(b_out, 8'hB8);
		pv = 8'hB8;
		for (int b = 0; b < 8; b++) begin
			op(IORSD_OP_SKIP_HIGH, 6'h05, 8'h00, 3'(b), 8'h00);
			check({7'h00, sk}, {7'h00, pv[b]});
			op(IORSD_OP_SKIP_LOW, 6'h05, 8'h00, 3'(b), 8'h00);
			check({7'h00, sk}, {7'h00, ~pv[b]});
		end
		// status flags: set by events, cleared only by written ones
		ev = 8'hFF;
		@(negedge clk);
		ev = 8'h00;
		for (int i = 0; i < 5; i++) begin
			op(IORSD_OP_IO_READ, FA[i], 8'h00, 3'd0, 8'h00);
			check(rd, FM[i]);
		end
		check(t0f, 8'h07);
		check(t2f, 8'h07);
		check(pcf, 8'h07);
		op(IORSD_OP_SET_BIT, 6'h16, 8'h00, 3'd0, 8'h00);
		check(t1f, 8'h26);
		op(IORSD_OP_CLEAR_BIT, 6'h16, 8'h00, 3'd5, 8'h00);
		check(t1f, 8'h26);
		op(IORSD_OP_IO_WRITE, 6'h16, 8'h00, 3'd0, 8'h04);
		check(t1f, 8'h22);
		op(IORSD_OP_MEM_STORE, 6'h00, 8'h36, 3'd0, 8'h00);
		check(t1f, 8'h22);
		op(IORSD_OP_MEM_STORE, 6'h00, 8'h36, 3'd0, 8'h22);
		check(t1f, 8'h00);
		op(IORSD_OP_IO_WRITE, 6'h1C, 8'h00, 3'd0, 8'h01);
		check(exf, 8'h02);
		// pin inputs after the synchroniser settles; pin registers ignore bit ops
		{pb, pc, pd} = {8'h5A, 7'h33, 8'hA5};
		repeat (6) @(negedge clk);
		op(IORSD_OP_IO_READ, 6'h09, 8'h00, 3'd0, 8'h00);
		check(rd, 8'hA5);
		op(IORSD_OP_IO_READ, 6'h06, 8'h00, 3'd0, 8'h00);
		check(rd, 8'h33);
		op(IORSD_OP_SET_BIT, 6'h03, 8'h00, 3'd0, 8'h00);
		op(IORSD_OP_MEM_LOAD, 6'h00, 8'h23, 3'd0, 8'h00);
		check(rd, 8'h5A);
		// reserved places refuse writes and read zero
		for (int i = 0; i < 3; i++) begin
			op(IORSD_OP_IO_WRITE, RS[i], 8'h00, 3'd0, 8'hFF);
			check({7'h00, er}, 8'h01);
			op(IORSD_OP_IO_READ, RS[i], 8'h00, 3'd0, 8'h00);
			check(rd, 8'h00);
		end
		op(IORSD_OP_NONE, 6'h00, 8'h00, 3'd0, 8'h00);
		check({7'h00, er}, 8'h01);
		op(IORSD_OP_MEM_LOAD, 6'h00, 8'h10, 3'd0, 8'h00);
		check({7'h00, er}, 8'h01);
		// extended region and upper io half use the peripheral port
		op(IORSD_OP_MEM_STORE, 6'h00, 8'h80, 3'd0, 8'hC3);
		check(ext_addr, 8'h80);
		check(ext_wdata, 8'hC3);
		op(IORSD_OP_MEM_LOAD, 6'h00, 8'hFF, 3'd0, 8'h00);
		check(rd, 8'hA5);
		op(IORSD_OP_IO_READ, 6'h30, 8'h00, 3'd0, 8'h00);
		check(rd, 8'h0A);
		op(IORSD_OP_IO_WRITE, 6'h3F, 8'h00, 3'd0, 8'h11);
		check(ext_addr, 8'h5F);
		// mid-run reset
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		check(b_out, 8'h00);
		check(exf, 8'h00);
		test_done();
	end
endmodule

bind iorsd_top iorsd_top_monitor i_mon (.*);
